// File: logic/wao_map.vh
// wao_map.vh: register offsets, field positions, reset values and
// converter code levels for the weight to analog output mapper.
// assumes word-indexed register addresses on a plain strobe port.
`ifndef WAO_MAP_VH
`define WAO_MAP_VH

// register word indices
`define WAO_ADDR_W          4
`define WAO_REG_CTRL        4'h0
`define WAO_REG_ZERO        4'h1
`define WAO_REG_HIGH        4'h2
`define WAO_REG_MAX         4'h3
`define WAO_REG_STAT        4'h4
`define WAO_REG_CODE        4'h5

// control register fields
`define WAO_CTRL_SRC_LSB    0
`define WAO_CTRL_SRC_MSB    2
`define WAO_CTRL_MODE_BIT   4
`define WAO_CTRL_RATE_BIT   5

// status register fields
`define WAO_STAT_BUSY_BIT   0
`define WAO_STAT_LO_BIT     1
`define WAO_STAT_HI_BIT     2

// source selection codes
`define WAO_SRC_DISP        3'h0
`define WAO_SRC_MAG_DISP    3'h1
`define WAO_SRC_GROSS       3'h2
`define WAO_SRC_RATE        3'h3
`define WAO_SRC_MAG_RATE    3'h4

// output mode
`define WAO_MODE_CURRENT    1'b0
`define WAO_MODE_VOLTAGE    1'b1

// code span: current 0..24 mA, voltage -2.4..12.5 V over 0000..FFFF
`define WAO_CUR_FAULT_LO    16'h0000
`define WAO_CUR_FAULT_HI    16'hFFFF
`define WAO_VLT_FAULT_LO    16'h0000
`define WAO_VLT_FAULT_HI    16'hFFFF
`define WAO_CODE_MAX        16'hFFFF

// reset values: nominal 4 mA / 20 mA calibration points
`define WAO_ZERO_RST        16'h2AAA
`define WAO_HIGH_RST        16'hD555
`define WAO_MAX_RST         32'h0000_2710
`define WAO_CTRL_RST        32'h0000_0000

`endif

// File: logic/wao_div.v
// wao_div.v: iterative restoring divider, one quotient bit per cycle.
// assumes start is only honoured while idle; a zero divisor gives
// an all-ones quotient, which the caller treats as over-range, or as under-range for a negative sample.
`timescale 1ns/100ps

module wao_div #(
    parameter NUM_W = 48,                    // dividend width
    parameter DEN_W = 32                     // divisor width
) (
    input  wire             clk_i,           // system clock
    input  wire             rst_i,           // async reset, high
    input  wire             start_i,         // begin a division
    input  wire [NUM_W-1:0] num_i,           // dividend
    input  wire [DEN_W-1:0] den_i,           // divisor
    output reg              busy_o,          // division running
    output reg              done_o,          // quotient ready pulse
    output reg  [NUM_W-1:0] quot_o           // quotient
);

    localparam integer LAST_I = NUM_W - 1;   // final step index, wide
    localparam [5:0]   LAST   = LAST_I[5:0]; // final step index

    reg  [DEN_W:0]   rem;                    // partial remainder
    reg  [DEN_W-1:0] den;                    // held divisor
    reg  [5:0]       cnt;                    // step counter
    wire [DEN_W:0]   rem_sh;                 // shifted remainder
    wire             next_bit;               // quotient bit
    wire [DEN_W:0]   next_rem;               // remainder after step

    // one restoring step
    assign rem_sh   = {rem[DEN_W-1:0], quot_o[NUM_W-1]};
    assign next_bit = (rem_sh >= {1'b0, den});
    assign next_rem = next_bit ? (rem_sh - {1'b0, den}) : rem_sh;

    // step sequencer
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            busy_o <= 1'b0;
            done_o <= 1'b0;
            quot_o <= {NUM_W{1'b0}};
            rem    <= {(DEN_W+1){1'b0}};
            den    <= {DEN_W{1'b0}};
            cnt    <= 6'h00;
        end else begin
            done_o <= 1'b0;
            if (start_i && !busy_o) begin    // load operands
                busy_o <= 1'b1;
                quot_o <= num_i;
                den    <= den_i;
                rem    <= {(DEN_W+1){1'b0}};
                cnt    <= 6'h00;
            end else if (busy_o) begin       // shift one bit in
                rem    <= next_rem;
                quot_o <= {quot_o[NUM_W-2:0], next_bit};
                cnt    <= cnt + 6'h01;
                if (cnt == LAST) begin
                    busy_o <= 1'b0;
                    done_o <= 1'b1;
                end
            end
        end
    end

endmodule // wao_div

// File: logic/wao_sat.v
// wao_sat.v: folds a signed wide result into the 16-bit code span and
// reports which end was exceeded.
// assumes a two's complement input wider than the code.
`timescale 1ns/100ps
`include "wao_map.vh"

module wao_sat #(
    parameter IN_W = 50                      // input width
) (
    input  wire [IN_W-1:0] val_i,            // signed result
    output wire [15:0]     code_o,           // clamped code
    output wire            under_o,          // below code span
    output wire            over_o            // above code span
);

    // negative means below the bottom of the converter span
    assign under_o = val_i[IN_W-1];
    // any bit above the code width means above the top
    assign over_o  = !val_i[IN_W-1] && (|val_i[IN_W-2:16]);
    assign code_o  = under_o ? 16'h0000 :
                     over_o  ? `WAO_CODE_MAX : val_i[15:0];

endmodule // wao_sat

// File: logic/wao_mapper.v
// wao_mapper.v: maps one selected weight or rate source to the 16-bit
// analog output converter code, with calibrated ends and fault levels.
// assumes weight, rate, blanking and strobe inputs come from logic on
// ref_clk_i; the converter takes dac_code_o when dac_load_o pulses.
`timescale 1ns/100ps
`include "wao_map.vh"

module wao_mapper (
    input  wire        ref_clk_i,            // 10 MHz system clock
    input  wire        sys_rst_i,            // async reset, high
    input  wire [3:0]  reg_addr_i,           // register word index
    input  wire [31:0] reg_wdata_i,          // register write data
    input  wire        reg_wr_i,             // write strobe
    input  wire        reg_rd_i,             // read strobe
    output reg  [31:0] reg_rdata_o,          // read data, next cycle
    input  wire [31:0] disp_wt_i,            // displayed weight, signed
    input  wire [31:0] gross_wt_i,           // gross weight, signed
    input  wire        wt_valid_i,           // new weight sample
    input  wire [31:0] rate_i,               // rate, signed
    input  wire        rate_valid_i,         // new rate sample
    input  wire        blank_under_i,        // display blanked low
    input  wire        blank_over_i,         // display blanked high
    input  wire        gross_mode_i,         // terminal in gross mode
    output reg  [15:0] dac_code_o,           // converter code
    output reg         dac_load_o,           // code update pulse
    output wire        out_mode_o,           // 1 voltage, 0 current
    output reg         fault_lo_o,           // bottom fault forced
    output reg         fault_hi_o            // top fault forced
);

    // state codes
    localparam [1:0] ST_IDLE = 2'b00;        // waiting for a sample
    localparam [1:0] ST_DIV  = 2'b01;        // scaling in progress

    // configuration registers
    reg  [2:0]  src;                         // selected source
    reg         mode;                        // output mode
    reg         rate_en;                     // rate function enabled
    reg  [15:0] zero_cal;                    // calibrated zero code
    reg  [15:0] high_cal;                    // calibrated high code
    reg  [31:0] max_val;                     // quantity at high limit

    // sequencing
    reg  [1:0]  state;                       // current state
    reg         neg;                         // result below zero code
    reg  [31:0] mag;                         // magnitude of sample
    reg         div_start;                   // divider start pulse
    wire        busy;                        // sample being scaled

    // selected sample
    reg  [31:0] samp;                        // sample of chosen source
    reg         samp_stb;                    // sample strobe
    reg         is_wt;                       // a weight source
    reg         is_mag;                      // a magnitude source
    wire [31:0] samp_mag;                    // sample magnitude
    wire        samp_neg;                    // sample sign
    wire        mag_over;                    // magnitude above maximum

    // scaling path
    wire [15:0] span;                        // high minus zero code
    wire [47:0] prod;                        // magnitude times span
    wire [47:0] quot;                        // scaled offset
    wire        div_busy;                    // divider running
    wire        div_done;                    // divider finished
    wire [49:0] res;                         // zero plus signed offset
    wire [15:0] sat_code;                    // clamped result
    wire        sat_under;                   // result below span
    wire        sat_over;                    // result above span

    // forcing decisions
    reg         force_lo;                    // force bottom level
    reg         force_hi;                    // force top level
    wire [15:0] fault_lo_code;               // bottom level for mode
    wire [15:0] fault_hi_code;               // top level for mode
    wire        src_ok;                      // requested source legal
    wire [2:0]  wsrc;                        // requested source

    // one output channel, mode from control
    // a mode change reaches out_mode_o in the cycle after the write; no code is re-issued
    assign out_mode_o = mode;

    // fault levels sit at the ends of the code span; the analog stage
    // maps 0000 and FFFF to the bottom and top fault levels
    assign fault_lo_code = (mode == `WAO_MODE_VOLTAGE) ?
                           `WAO_VLT_FAULT_LO :
                           `WAO_CUR_FAULT_LO;
    assign fault_hi_code = (mode == `WAO_MODE_VOLTAGE) ?
                           `WAO_VLT_FAULT_HI :
                           `WAO_CUR_FAULT_HI;

    // requested source check on a control write
    // rate codes need the enable bit of the same write, not the stored one
    assign wsrc   = reg_wdata_i[`WAO_CTRL_SRC_MSB:`WAO_CTRL_SRC_LSB];
    assign src_ok = (wsrc <= `WAO_SRC_GROSS) ||
                    (((wsrc == `WAO_SRC_RATE) ||
                      (wsrc == `WAO_SRC_MAG_RATE)) &&
                     reg_wdata_i[`WAO_CTRL_RATE_BIT]);

    // register writes; a refused source request keeps the old choice, unless
    // a rate source is chosen and the write clears the rate enable, which
    // falls back to displayed weight, so a bad write never points the output at a disabled rate source
    always @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            src      <= `WAO_SRC_DISP;
            mode     <= `WAO_MODE_CURRENT;
            rate_en  <= 1'b0;
            zero_cal <= `WAO_ZERO_RST;
            high_cal <= `WAO_HIGH_RST;
            max_val  <= `WAO_MAX_RST;
        end else if (reg_wr_i) begin
            case (reg_addr_i)
                `WAO_REG_CTRL: begin         // mode, rate enable, source
                    mode    <= reg_wdata_i[`WAO_CTRL_MODE_BIT];
                    rate_en <= reg_wdata_i[`WAO_CTRL_RATE_BIT];
                    if (src_ok) begin
                        src <= wsrc;
                    end else if (src >= `WAO_SRC_RATE &&
                                 !reg_wdata_i[`WAO_CTRL_RATE_BIT]) begin
                        src <= `WAO_SRC_DISP;
                    end
                end
                `WAO_REG_ZERO: begin         // zero calibration
                    zero_cal <= reg_wdata_i[15:0];
                end
                `WAO_REG_HIGH: begin         // high calibration
                    high_cal <= reg_wdata_i[15:0];
                end
                `WAO_REG_MAX: begin          // quantity at high limit
                    max_val <= reg_wdata_i;
                end
                default: begin               // unmapped, ignored
                end
            endcase
        end
    end

    // register reads, data in the following cycle
    // zero outside the answer cycle, so slaves may be ORed together
    always @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            reg_rdata_o <= 32'h0000_0000;
        end else if (reg_rd_i) begin
            case (reg_addr_i)
                `WAO_REG_CTRL: reg_rdata_o <= {26'h000_0000, rate_en,
                                               mode, 1'b0, src};
                `WAO_REG_ZERO: reg_rdata_o <= {16'h0000, zero_cal};
                `WAO_REG_HIGH: reg_rdata_o <= {16'h0000, high_cal};
                `WAO_REG_MAX:  reg_rdata_o <= max_val;
                `WAO_REG_STAT: reg_rdata_o <= {29'h0000_0000, fault_hi_o,
                                               fault_lo_o,
                                               busy};
                `WAO_REG_CODE: reg_rdata_o <= {16'h0000, dac_code_o};
                default:       reg_rdata_o <= 32'h0000_0000;
            endcase
        end else begin
            reg_rdata_o <= 32'h0000_0000;   // stands one cycle only
        end
    end

    // source multiplexer
    // the strobe follows the chosen source; a strobe of the other kind
    // is ignored, so a weight update never re-issues a rate code
    always @* begin
        samp     = disp_wt_i;
        samp_stb = wt_valid_i;
        is_wt    = 1'b1;
        is_mag   = 1'b0;
        case (src)
            `WAO_SRC_DISP: begin             // displayed weight
                samp = disp_wt_i;
            end
            `WAO_SRC_MAG_DISP: begin         // displayed magnitude
                is_mag = 1'b1;
            end
            `WAO_SRC_GROSS: begin            // gross weight
                samp = gross_wt_i;
            end
            `WAO_SRC_RATE: begin             // signed rate
                samp     = rate_i;
                samp_stb = rate_valid_i;
                is_wt    = 1'b0;
            end
            `WAO_SRC_MAG_RATE: begin         // rate magnitude
                samp     = rate_i;
                samp_stb = rate_valid_i;
                is_wt    = 1'b0;
                is_mag   = 1'b1;
            end
            default: begin                   // unreachable codes
                samp_stb = 1'b0;
            end
        endcase
    end

    // magnitude and sign of the sample
    // the most negative value keeps its own pattern as magnitude,
    // which still compares above any sane maximum
    assign samp_neg = samp[31] && !is_mag;
    assign samp_mag = samp[31] ? (32'h0000_0000 - samp) : samp;
    assign mag_over = (samp_mag > max_val);

    // forcing decisions per source
    // low beats high: a blanked-under display never shows the top level
    always @* begin
        force_lo = 1'b0;
        force_hi = 1'b0;
        if (is_wt) begin
            force_lo = blank_under_i;
            if (src == `WAO_SRC_MAG_DISP) begin
                force_hi = blank_over_i && gross_mode_i;
            end else begin
                force_hi = blank_over_i;
            end
        end else begin
            force_lo = samp_neg;
            force_hi = mag_over && !samp_neg;
        end
    end

    // linear scaling: offset = magnitude * span / maximum
    // a high point at or below the zero point gives a flat output
    assign span = (high_cal > zero_cal) ? (high_cal - zero_cal) : 16'h0000;
    // the divider loads one cycle after the strobe, so it takes the
    // magnitude latched at the strobe, never the live sample
    assign prod = {16'h0000, mag} * {32'h0000_0000, span};

    // busy spans the start cycle and the whole divide
    assign busy = (state != ST_IDLE) || div_busy;

    wao_div #(
        .NUM_W (48),
        .DEN_W (32)
    ) u_div (
        .clk_i   (ref_clk_i),
        .rst_i   (sys_rst_i),
        .start_i (div_start),
        .num_i   (prod),
        .den_i   (max_val),
        .busy_o  (div_busy),
        .done_o  (div_done),
        .quot_o  (quot)
    );

    // add or subtract the offset around the calibrated zero
    // kept wide so an overshoot past either end reaches the clamp
    // instead of wrapping back into the code span
    assign res = neg ? ({34'h0_0000_0000, zero_cal} - {2'b00, quot}) :
                       ({34'h0_0000_0000, zero_cal} + {2'b00, quot});

    wao_sat #(
        .IN_W (50)
    ) u_sat (
        .val_i   (res),
        .code_o  (sat_code),
        .under_o (sat_under),
        .over_o  (sat_over)
    );

    // sample sequencer and code latch
    // strobes arriving during a division are dropped; the first sample
    // after the load is taken, so a fast source lowers the update rate
    // and never queues stale values. a forced level answers in the
    // cycle after its strobe, a scaled one once the quotient is in;
    // either way dac_load_o pulses once
    always @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            state      <= ST_IDLE;
            neg        <= 1'b0;
            mag        <= 32'h0000_0000;
            div_start  <= 1'b0;
            dac_code_o <= `WAO_ZERO_RST;
            dac_load_o <= 1'b0;
            fault_lo_o <= 1'b0;
            fault_hi_o <= 1'b0;
        end else begin
            div_start  <= 1'b0;
            dac_load_o <= 1'b0;
            case (state)
                ST_IDLE: begin               // wait for a fresh sample
                    if (samp_stb) begin
                        if (force_lo) begin
                            dac_code_o <= fault_lo_code;
                            dac_load_o <= 1'b1;
                            fault_lo_o <= 1'b1;
                            fault_hi_o <= 1'b0;
                        end else if (force_hi) begin
                            dac_code_o <= fault_hi_code;
                            dac_load_o <= 1'b1;
                            fault_lo_o <= 1'b0;
                            fault_hi_o <= 1'b1;
                        end else begin
                            neg       <= samp_neg;
                            mag       <= samp_mag;
                            div_start <= 1'b1;
                            state     <= ST_DIV;
                        end
                    end
                end
                ST_DIV: begin                // wait for the quotient
                    if (div_done) begin
                        state      <= ST_IDLE;
                        dac_load_o <= 1'b1;
                        if (sat_under) begin
                            dac_code_o <= fault_lo_code;
                            fault_lo_o <= 1'b1;
                            fault_hi_o <= 1'b0;
                        end else if (sat_over) begin
                            dac_code_o <= fault_hi_code;
                            fault_lo_o <= 1'b0;
                            fault_hi_o <= 1'b1;
                        end else begin
                            dac_code_o <= sat_code;
                            fault_lo_o <= 1'b0;
                            fault_hi_o <= 1'b0;
                        end
                    end
                end
                default: begin               // recover to idle
                    state <= ST_IDLE;
                end
            endcase
        end
    end

endmodule // wao_mapper

// File: tb/wao_mapper_props.sv
// wao_mapper_props.sv: port assertions for the analog output mapper.
// assumes one clock domain; bound to every wao_mapper instance.
`timescale 1ns/100ps
module wao_mapper_props (
    input wire        ref_clk_i,    // system clock
    input wire        sys_rst_i,    // async reset, high
    input wire [3:0]  reg_addr_i,   // register index
    input wire [31:0] reg_wdata_i,  // write data
    input wire        reg_wr_i,     // write strobe
    input wire        reg_rd_i,     // read strobe
    input wire [31:0] reg_rdata_o,  // read data
    input wire        wt_valid_i,   // weight sample
    input wire        rate_valid_i, // rate sample
    input wire [15:0] dac_code_o,   // converter code
    input wire        dac_load_o,   // load pulse
    input wire        out_mode_o,   // output mode
    input wire        fault_lo_o,   // bottom fault
    input wire        fault_hi_o    // top fault
);
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (sys_rst_i);
    // code read whose answer cycle carries no fresh load
    sequence s_code_read;
        reg_rd_i && reg_addr_i == 4'h5 ##1 !dac_load_o;
    endsequence
    a_rdata_idle: assert property (!$past(reg_rd_i) |->
        reg_rdata_o == 32'h0000_0000) else $error("read data standing");
    a_code_read: assert property (s_code_read |->
        reg_rdata_o == {16'h0000, dac_code_o}) else $error("code read bad");
    a_load_pulse: assert property (dac_load_o |=> !dac_load_o ||
        $past(wt_valid_i | rate_valid_i)) else $error("load repeated");
    a_code_hold: assert property (!dac_load_o |->
        $stable({dac_code_o, fault_lo_o, fault_hi_o})) else $error("moved");
    a_load_cause: assert property (dac_load_o |->
        $past(wt_valid_i | rate_valid_i) ||
        $past(wt_valid_i | rate_valid_i, 51)) else $error("stray load");
    a_fault_lo_code: assert property (fault_lo_o |->
        dac_code_o == 16'h0000) else $error("low fault code wrong");
    a_fault_hi_code: assert property (fault_hi_o |->
        dac_code_o == 16'hFFFF) else $error("high fault code wrong");
    a_mode_write: assert property (reg_wr_i && reg_addr_i == 4'h0 |=>
        out_mode_o == $past(reg_wdata_i[4])) else $error("mode not taken");
endmodule // wao_mapper_props

bind wao_mapper wao_mapper_props i_props (.ref_clk_i(ref_clk_i),
    .sys_rst_i(sys_rst_i), .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i),
    .reg_wdata_i(reg_wdata_i), .reg_rd_i(reg_rd_i), .wt_valid_i(wt_valid_i),
    .reg_rdata_o(reg_rdata_o), .rate_valid_i(rate_valid_i),
    .dac_code_o(dac_code_o), .dac_load_o(dac_load_o),
    .out_mode_o(out_mode_o), .fault_lo_o(fault_lo_o), .fault_hi_o(fault_hi_o));

// File: tb/wao_dac_model.sv
// wao_dac_model.sv: converter at the far side, holds each loaded code.
// assumes a one-cycle load pulse on the system clock.
`timescale 1ns/100ps
module wao_dac_model (
    input  wire        ref_clk_i,   // system clock
    input  wire        sys_rst_i,   // async reset, high
    input  wire        load_i,      // code update pulse
    input  wire [15:0] code_i,      // converter code
    output reg  [15:0] level_o      // level held at the output
);
    // latch the whole 16-bit code at each load, hold it otherwise
    always @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i)
            level_o <= 16'h0000;
        else if (load_i)
            level_o <= code_i;
    end
endmodule // wao_dac_model

// File: tb/tb_wao_mapper.sv
// tb_wao_mapper.sv: self-checking bench for the analog output mapper.
// assumes the mapper, its header and the converter model are compiled.
`timescale 1ns/100ps
`define CHK(a, b) begin num_checks = num_checks + 1; if ((a) !== (b)) \
    begin bad_count = bad_count + 1; \
    $display("unexpected %0t %h %h", $time, (a), (b)); end end
module tb_wao_mapper;
    reg         ref_clk = 1'b0, sys_rst = 1'b1; // clock, reset
    reg         wr = 1'b0, rd = 1'b0, gmode = 1'b0; // strobes, gross
    reg         wt_v = 1'b0, rate_v = 1'b0;     // sample strobes
    reg  [1:0]  blank = 2'h0;                   // {over, under}
    reg  [3:0]  addr = 4'h0;                    // register index
    reg  [31:0] wdata = 32'h0, val = 32'h0;     // write data, sample
    wire [31:0] rdata;                          // read data
    wire [15:0] code, level;                    // code, converter level
    wire        load, mode, flo, fhi;           // pulse, mode, faults
    integer     bad_count = 0, num_checks = 0, n = 0;
    initial forever #50 ref_clk = ~ref_clk;
    // gross weight sits 2000 below the displayed value to tell them apart
    wao_mapper i_dut (.ref_clk_i(ref_clk), .sys_rst_i(sys_rst),
        .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr),
        .reg_rd_i(rd), .reg_rdata_o(rdata), .disp_wt_i(val),
        .gross_wt_i(val - 32'h0000_07D0), .wt_valid_i(wt_v),
        .rate_i(val), .rate_valid_i(rate_v), .blank_under_i(blank[0]),
        .blank_over_i(blank[1]), .gross_mode_i(gmode), .dac_code_o(code),
        .dac_load_o(load), .out_mode_o(mode), .fault_lo_o(flo),
        .fault_hi_o(fhi));
    wao_dac_model i_dac (.ref_clk_i(ref_clk), .sys_rst_i(sys_rst),
        .load_i(load), .code_i(code), .level_o(level));
    task bus(input w, input [3:0] a, input [31:0] d); // write, or read+check
        @(posedge ref_clk);
        addr <= a;
        wdata <= d;
        wr <= w;
        rd <= ~w;
        @(posedge ref_clk);
        wr <= 1'b0;
        rd <= 1'b0;
        @(negedge ref_clk);
        if (!w)
            `CHK(rdata, d)
    endtask
    // one sample, wait for its load, judge latency, code, flags, level
    task smp(input r, input [1:0] b, input [31:0] v, input [15:0] ec,
             input [1:0] ef, input integer lat);
        @(posedge ref_clk);
        blank <= b;
        val <= v;
        wt_v <= ~r;
        rate_v <= r;
        @(posedge ref_clk);
        wt_v <= 1'b0;
        rate_v <= 1'b0;
        @(negedge ref_clk);
        for (n = 1; n < 60 && load !== 1'b1; n = n + 1)
            @(negedge ref_clk);
        `CHK(n, lat)
        if (n == 60)
            wrap_up;
        `CHK({fhi, flo, code}, {ef, ec})
        @(negedge ref_clk);
        `CHK(level, ec)
    endtask
    task wrap_up;
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task t_reset; // reset levels and register defaults
        @(negedge ref_clk);
        `CHK({load, fhi, flo, code}, 19'h0_2AAA)
        bus(1'b0, 4'h1, 32'h0000_2AAA);
        bus(1'b0, 4'h3, 32'h0000_2710);
        bus(1'b0, 4'h6, 32'h0000_0000);
    endtask
    task t_scale; // displayed weight in current mode
        smp(1'b0, 2'h0, 32'h0000_0000, 16'h2AAA, 2'h0, 51);
        smp(1'b0, 2'h0, 32'h0000_2710, 16'hD555, 2'h0, 51);
        smp(1'b0, 2'h0, 32'h0000_1388, 16'h7FFF, 2'h0, 51);
        smp(1'b0, 2'h0, 32'hFFFF_FC18, 16'h1999, 2'h0, 51);
        smp(1'b0, 2'h0, 32'h0000_4E20, 16'hFFFF, 2'h2, 51);
        bus(1'b0, 4'h5, 32'h0000_FFFF);
        smp(1'b0, 2'h1, 32'h0000_1388, 16'h0000, 2'h1, 1);
        smp(1'b0, 2'h2, 32'h0000_1388, 16'hFFFF, 2'h2, 1);
    endtask
    task t_src; // magnitude weight, then gross weight
        bus(1'b1, 4'h0, 32'h0000_0001);
        smp(1'b0, 2'h0, 32'hFFFF_EC78, 16'h7FFF, 2'h0, 51);
        smp(1'b0, 2'h2, 32'h0000_1388, 16'h7FFF, 2'h0, 51);
        @(posedge ref_clk) gmode <= 1'b1;
        smp(1'b0, 2'h2, 32'h0000_1388, 16'hFFFF, 2'h2, 1);
        smp(1'b0, 2'h1, 32'h0000_1388, 16'h0000, 2'h1, 1);
        bus(1'b1, 4'h0, 32'h0000_0002);
        smp(1'b0, 2'h0, 32'h0000_1B58, 16'h7FFF, 2'h0, 51);
        smp(1'b0, 2'h0, 32'h0000_03E8, 16'h1999, 2'h0, 51);
    endtask
    task t_rate; // rate sources and the rate enable gate
        bus(1'b1, 4'h0, 32'h0000_0003);
        bus(1'b0, 4'h0, 32'h0000_0002);
        bus(1'b1, 4'h0, 32'h0000_0023);
        smp(1'b1, 2'h0, 32'hFFFF_FC18, 16'h0000, 2'h1, 1);
        smp(1'b1, 2'h0, 32'h0000_1388, 16'h7FFF, 2'h0, 51);
        smp(1'b1, 2'h0, 32'h0000_4E20, 16'hFFFF, 2'h2, 1);
        bus(1'b1, 4'h0, 32'h0000_0024);
        smp(1'b1, 2'h0, 32'hFFFF_EC78, 16'h7FFF, 2'h0, 51);
        bus(1'b1, 4'h0, 32'h0000_0004);
        bus(1'b0, 4'h0, 32'h0000_0000);
    endtask
    task t_volt; // voltage mode with recalibrated ends
        bus(1'b1, 4'h0, 32'h0000_0010);
        bus(1'b0, 4'h0, 32'h0000_0010);
        `CHK(mode, 1'b1)
        bus(1'b1, 4'h1, 32'h0000_293C);
        bus(1'b1, 4'h2, 32'h0000_D50C);
        smp(1'b0, 2'h0, 32'h0000_2710, 16'hD50C, 2'h0, 51);
        smp(1'b0, 2'h1, 32'h0000_1388, 16'h0000, 2'h1, 1);
        smp(1'b0, 2'h2, 32'h0000_1388, 16'hFFFF, 2'h2, 1);
    endtask
    initial begin
        repeat (20) @(posedge ref_clk);
        sys_rst <= 1'b0;
        t_reset;
        t_scale;
        t_src;
        t_rate;
        t_volt;
        wrap_up;
    end
endmodule // tb_wao_mapper
